/* design/reset_ctrl_pkg.sv */
// Purpose: Shared constants and types for the reset controller
// Assumes: 25 MHz system clock
// Notes: Cycle counts derive from printed times
package reset_ctrl_pkg;

  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // Times and cycle counts
  // ----------------------------------------------------------------
  localparam int POR_INIT_NS = 143000;
  localparam int POR_INIT_CYC = (POR_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int WDT_PULSE_CYC = 49;
  localparam int CA_PULSE_CYC = 16;
  localparam int COMPAT_SAMPLE_DIV = 6;
  localparam int PIN_INACT_SAMPLES = 2;
  // Start-up times in us, index {crystal, fuse1, fuse0}
  localparam int SUT_US [8] = '{16, 512, 1024, 4096,
                                1024, 2048, 4096, 16384};
  localparam logic [7:0][CNT_W-1:0] SUT_CYC_TABLE = {
    CNT_W'(SUT_US[7] * CLK_MHZ), CNT_W'(SUT_US[6] * CLK_MHZ),
    CNT_W'(SUT_US[5] * CLK_MHZ), CNT_W'(SUT_US[4] * CLK_MHZ),
    CNT_W'(SUT_US[3] * CLK_MHZ), CNT_W'(SUT_US[2] * CLK_MHZ),
    CNT_W'(SUT_US[1] * CLK_MHZ), CNT_W'(SUT_US[0] * CLK_MHZ)};

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_WATCHDOG_PROGRAM = 8'ha7;
  localparam logic [7:0] ADDR_WATCHDOG_RESTART = 8'ha6;
  localparam int POWER_CONTROL_REG_PD_BIT = 1;
  localparam int POWER_CONTROL_REG_POF_BIT = 4;
  localparam int POWER_CONTROL_REG_PWDEX_BIT = 5;
  localparam logic [7:0] POWER_CONTROL_REG_RESET = 8'h00;
  localparam int WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT = 5;
  localparam int WATCHDOG_PROGRAM_REG_SOFT_BIT = 6;
  localparam int WATCHDOG_PROGRAM_REG_OVF_BIT = 7;
  localparam logic [7:0] WATCHDOG_PROGRAM_REG_RESET = 8'h00;
  localparam logic [7:0] SEQ_SW_FIRST = 8'h5a;
  localparam logic [7:0] SEQ_SW_SECOND = 8'ha5;
  localparam logic [7:0] SEQ_KICK_FIRST = 8'h1e;
  localparam logic [7:0] SEQ_KICK_SECOND = 8'he1;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_SUT = 2'b01,
    ST_PULSE = 2'b10,
    ST_RUN = 2'b11
  } rc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    rc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic drive_b;
    logic wake_only;
    logic powerup;
    logic [1:0] por_s;
    logic [1:0] bod_s;
    logic [1:0] pin_s;
    logic [1:0] sel_s;
    logic [1:0] drove_s;
    logic [1:0] glitch;
    logic pin_act;
    logic [1:0] inact;
    logic [2:0] div6;
    logic isp;
    logic [7:0] power_control_reg;
    logic [7:0] watchdog_program_reg;
    logic seq_pend;
    logic [7:0] seq_first;
    logic kick;
    logic [7:0] rdata;
    logic core_reset;
    logic clk_hold;
  } rc_regs_t;

  localparam rc_regs_t RC_REGS_RESET = '{
    state: ST_INIT,
    cnt: CNT_W'(POR_INIT_CYC - 1),
    drive_b: 1'b1,
    drove_s: 2'b11,
    powerup: 1'b1,
    power_control_reg: 8'h10,
    core_reset: 1'b1,
    default: '0};

endpackage

/* design/reset_controller.sv */
// Purpose: Reset source merge, start-up delay, reset pin handling
// Assumes: Single 25 MHz clock; detectors and pins are asynchronous
// Notes: Core resumes at the reset vector when core_reset falls
//
// Behaviour
// - Reset returns registers to initial values
// - Six sources assert the internal reset
// - Init interval, then start-up count above threshold
// - Power-on sets the power-off flag
// - Pin held active extends the reset
// - Fuses and clock source pick start-up delay
// - Same delay after brown-out and timed wake
// - Power-on always drives the reset pin
// - Brown-out resets at once, releases after delay
// - Brown-out alone never drives the pin
// - Sense select sets reset pin polarity
// - Pin pulses under 50 ns are ignored
// - Compatibility mode: sample per six, two inactive
// - Fast mode: sample each clock, two inactive
// - Held pin enables programming, fuse limits it
// - Watchdog time-out gives 49-clock pulse, pin optional
// - Watchdog reset sets the overflow flag
// - Array watchdog gives 16-clock internal pulse only
// - 5A then A5 gives soft reset, flag
// - Bad sequence resets and sets both flags
// - Soft reset drives pin unless disabled
// - Power-off flag writable, kept over warm resets
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module reset_controller #(
  parameter logic [7:0][reset_ctrl_pkg::CNT_W-1:0] SUT_CYCLES =
    reset_ctrl_pkg::SUT_CYC_TABLE
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire reset_ctrl_pkg::reg_req_t req,
  output logic [7:0] rdata,
  input wire logic por_detect,
  input wire logic bod_low,
  input wire logic rst_pin_in,
  input wire logic reset_sense_select,
  input wire logic [1:0] startup_delay_fuses,
  input wire logic xtal_source,
  input wire logic fast_mode,
  input wire logic isp_fuse_disable,
  input wire logic hw_wdt_timeout,
  input wire logic ca_wdt_match,
  input wire logic pd_wake,
  output logic core_reset,
  output logic rst_pin_out,
  output logic rst_pin_oe_b,
  output logic isp_enable,
  output logic core_clk_hold,
  output logic wdt_kick
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_chk
    if (SUT_CYCLES[i] < 1) begin : g_bad
      $error("start-up count must be at least one cycle");
    end
  end
  if (reset_ctrl_pkg::POR_INIT_CYC >= 2 ** reset_ctrl_pkg::CNT_W)
  begin : g_bad_init
    $error("init interval does not fit the counter");
  end

  localparam logic [reset_ctrl_pkg::CNT_W-1:0] INIT_LOAD =
    reset_ctrl_pkg::CNT_W'(reset_ctrl_pkg::POR_INIT_CYC - 1);
  localparam logic [reset_ctrl_pkg::CNT_W-1:0] WDT_LOAD =
    reset_ctrl_pkg::CNT_W'(reset_ctrl_pkg::WDT_PULSE_CYC - 1);
  localparam logic [reset_ctrl_pkg::CNT_W-1:0] CA_LOAD =
    reset_ctrl_pkg::CNT_W'(reset_ctrl_pkg::CA_PULSE_CYC - 1);

  function automatic logic [reset_ctrl_pkg::CNT_W-1:0] sut_load(
    input logic xtal, input logic [1:0] fuses);
    sut_load = SUT_CYCLES[{xtal, fuses}] - 1'b1;
  endfunction

  reset_ctrl_pkg::rc_regs_t st_reg;
  reset_ctrl_pkg::rc_regs_t st_next;

  logic por;
  logic bod;
  logic run;
  logic raw_act;
  logic samp;
  logic wr_rst;
  logic seq_sw;
  logic seq_kick;
  logic seq_bad;
  logic ev_hw;
  logic ev_sw;
  logic ev_ca;
  logic ev_wake;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign por = st_reg.por_s[1];
  assign bod = st_reg.bod_s[1];
  assign run = st_reg.state == reset_ctrl_pkg::ST_RUN && !por && !bod;
  // Own drive must not read back as an external request
  // Synchroniser still holds own drive for two cycles after release
  assign raw_act = st_reg.drive_b && st_reg.drove_s == 2'b00 &&
    (st_reg.pin_s[1] == st_reg.sel_s[1]);
  assign samp = fast_mode || st_reg.div6 == 3'h0;
  assign wr_rst = req.wr &&
    req.addr == reset_ctrl_pkg::ADDR_WATCHDOG_RESTART;
  assign seq_sw = wr_rst && st_reg.seq_pend &&
    st_reg.seq_first == reset_ctrl_pkg::SEQ_SW_FIRST &&
    req.wdata == reset_ctrl_pkg::SEQ_SW_SECOND;
  assign seq_kick = wr_rst && st_reg.seq_pend &&
    st_reg.seq_first == reset_ctrl_pkg::SEQ_KICK_FIRST &&
    req.wdata == reset_ctrl_pkg::SEQ_KICK_SECOND;
  assign seq_bad = (wr_rst && !st_reg.seq_pend &&
    req.wdata != reset_ctrl_pkg::SEQ_SW_FIRST &&
    req.wdata != reset_ctrl_pkg::SEQ_KICK_FIRST) ||
    (wr_rst && st_reg.seq_pend && !seq_sw && !seq_kick) ||
    (req.wr && !wr_rst && st_reg.seq_pend);
  assign ev_hw = run && hw_wdt_timeout;
  assign ev_sw = run && !hw_wdt_timeout && (seq_sw || seq_bad);
  assign ev_ca = run && !hw_wdt_timeout && !seq_sw && !seq_bad &&
    ca_wdt_match;
  assign ev_wake = run && !hw_wdt_timeout && !seq_sw && !seq_bad &&
    !ca_wdt_match && pd_wake &&
    st_reg.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_PWDEX_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.kick = seq_kick && run;
    st_next.rdata = 8'h00;
    st_next.por_s = {st_reg.por_s[0], por_detect};
    st_next.bod_s = {st_reg.bod_s[0], bod_low};
    st_next.pin_s = {st_reg.pin_s[0], rst_pin_in};
    st_next.sel_s = {st_reg.sel_s[0], reset_sense_select};
    st_next.drove_s = {st_reg.drove_s[0], !st_reg.drive_b};
    st_next.div6 = (st_reg.div6 ==
      3'(reset_ctrl_pkg::COMPAT_SAMPLE_DIV - 1)) ? 3'h0 :
      st_reg.div6 + 3'h1;

    // Pin filter and synchronous release
    if (raw_act) begin
      st_next.inact = 2'h0;
      if (st_reg.glitch < 2'(reset_ctrl_pkg::GLITCH_CYC)) begin
        st_next.glitch = st_reg.glitch + 2'h1;
      end
      if (st_next.glitch >= 2'(reset_ctrl_pkg::GLITCH_CYC)) begin
        st_next.pin_act = 1'b1;
      end
    end else begin
      st_next.glitch = 2'h0;
      if (samp && st_reg.pin_act) begin
        if (st_reg.inact ==
            2'(reset_ctrl_pkg::PIN_INACT_SAMPLES - 1)) begin
          st_next.pin_act = 1'b0;
          st_next.inact = 2'h0;
        end else begin
          st_next.inact = st_reg.inact + 2'h1;
        end
      end
    end

    // Register writes, ahead of hardware sets
    if (req.wr && req.addr == reset_ctrl_pkg::ADDR_POWER_CONTROL) begin
      st_next.power_control_reg = req.wdata;
    end
    if (req.wr &&
        req.addr == reset_ctrl_pkg::ADDR_WATCHDOG_PROGRAM) begin
      st_next.watchdog_program_reg = req.wdata;
    end
    if (wr_rst) begin
      st_next.seq_pend = !st_reg.seq_pend &&
        (req.wdata == reset_ctrl_pkg::SEQ_SW_FIRST ||
         req.wdata == reset_ctrl_pkg::SEQ_KICK_FIRST);
      st_next.seq_first = req.wdata;
    end else if (req.wr) begin
      st_next.seq_pend = 1'b0;
    end
    if (pd_wake) begin
      st_next.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_PD_BIT] = 1'b0;
    end
    if (req.rd) begin
      unique case (req.addr)
        reset_ctrl_pkg::ADDR_POWER_CONTROL:
          st_next.rdata = st_reg.power_control_reg;
        reset_ctrl_pkg::ADDR_WATCHDOG_PROGRAM:
          st_next.rdata = st_reg.watchdog_program_reg;
        default:
          st_next.rdata = 8'h00;
      endcase
    end

    // Reset sequencer
    if (por) begin
      st_next.state = reset_ctrl_pkg::ST_INIT;
      st_next.cnt = INIT_LOAD;
      st_next.drive_b = 1'b0;
      st_next.powerup = 1'b1;
      st_next.wake_only = 1'b0;
      st_next.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT] = 1'b1;
      st_next.watchdog_program_reg = reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET;
    end else if (bod) begin
      st_next.state = reset_ctrl_pkg::ST_SUT;
      st_next.cnt = sut_load(xtal_source, startup_delay_fuses);
      st_next.drive_b = 1'b1;
      st_next.wake_only = 1'b0;
    end else begin
      unique case (st_reg.state)
        reset_ctrl_pkg::ST_INIT: begin
          st_next.drive_b = 1'b1;
          if (st_reg.cnt == '0) begin
            st_next.state = reset_ctrl_pkg::ST_SUT;
            st_next.cnt = sut_load(xtal_source, startup_delay_fuses);
          end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
          end
        end
        reset_ctrl_pkg::ST_SUT: begin
          if (st_reg.cnt == '0) begin
            st_next.state = reset_ctrl_pkg::ST_RUN;
            st_next.wake_only = 1'b0;
          end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
          end
        end
        reset_ctrl_pkg::ST_PULSE: begin
          if (st_reg.cnt == '0) begin
            st_next.state = reset_ctrl_pkg::ST_RUN;
            st_next.drive_b = 1'b1;
          end else begin
            st_next.cnt = st_reg.cnt - 1'b1;
          end
        end
        reset_ctrl_pkg::ST_RUN: begin
          if (ev_hw) begin
            st_next.state = reset_ctrl_pkg::ST_PULSE;
            st_next.cnt = WDT_LOAD;
            st_next.drive_b =
              st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT];
            st_next.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_OVF_BIT] = 1'b1;
          end else if (ev_sw) begin
            st_next.state = reset_ctrl_pkg::ST_PULSE;
            st_next.cnt = WDT_LOAD;
            st_next.drive_b =
              st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT];
            st_next.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_SOFT_BIT] = 1'b1;
            if (seq_bad) begin
              st_next.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_OVF_BIT] = 1'b1;
            end
          end else if (ev_ca) begin
            st_next.state = reset_ctrl_pkg::ST_PULSE;
            st_next.cnt = CA_LOAD;
            st_next.drive_b = 1'b1;
          end else if (ev_wake) begin
            st_next.state = reset_ctrl_pkg::ST_SUT;
            st_next.cnt = sut_load(xtal_source, startup_delay_fuses);
            st_next.wake_only = 1'b1;
          end
        end
      endcase
    end

    // Merged reset and register re-initialisation
    st_next.core_reset = st_next.pin_act ||
      (st_next.state != reset_ctrl_pkg::ST_RUN && !st_next.wake_only);
    st_next.clk_hold = st_next.wake_only &&
      st_next.state == reset_ctrl_pkg::ST_SUT;
    if (st_next.core_reset) begin
      // Power-off flag and cause flags survive warm resets
      st_next.power_control_reg = reset_ctrl_pkg::POWER_CONTROL_REG_RESET;
      st_next.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT] =
        st_next.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT] |
        (por | st_reg.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT]);
      st_next.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT:0] =
        reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT:0];
      st_next.seq_pend = 1'b0;
    end else begin
      st_next.powerup = 1'b0;
    end
    st_next.isp = st_next.pin_act && (!isp_fuse_disable ||
      st_reg.powerup || st_reg.isp);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= reset_ctrl_pkg::RC_REGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign core_reset = st_reg.core_reset;
  assign rst_pin_out = st_reg.sel_s[1];
  assign rst_pin_oe_b = st_reg.drive_b;
  assign isp_enable = st_reg.isp;
  assign core_clk_hold = st_reg.clk_hold;
  assign wdt_kick = st_reg.kick;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_por_pin_drive: assert property (por |=> !rst_pin_oe_b)
    else $error("power-on did not drive the reset pin");
  a_por_sets_pof: assert property (
    por |=> st_reg.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT])
    else $error("power-on did not set power-off flag");
  a_bod_immediate: assert property (
    bod && !por |=> core_reset && rst_pin_oe_b)
    else $error("brown-out reset late or drove the pin");
  a_sut_waits_bod: assert property (
    st_reg.state == reset_ctrl_pkg::ST_SUT && bod |=>
    st_reg.cnt == sut_load($past(xtal_source),
      $past(startup_delay_fuses)))
    else $error("start-up counted below threshold");
  a_hw_pulse_len: assert property (
    ev_hw |-> ##49 core_reset ##1
    (!core_reset || st_reg.pin_act ||
     st_reg.state != reset_ctrl_pkg::ST_RUN))
    else $error("watchdog pulse not 49 clocks");
  a_hw_sets_ovf: assert property (
    ev_hw |=> st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_OVF_BIT])
    else $error("watchdog overflow flag not set");
  a_ca_no_pin: assert property (
    ev_ca |=> (core_reset && rst_pin_oe_b) [*8])
    else $error("array watchdog pulse wrong");
  a_sw_flag_pin: assert property (
    ev_sw && !st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_RESET_OUTPUT_DISABLE_BIT] |=>
    !rst_pin_oe_b && st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_SOFT_BIT])
    else $error("soft reset flag or pin drive missing");
  a_bad_seq_flags: assert property (
    run && !hw_wdt_timeout && seq_bad |=>
    st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_OVF_BIT] &&
    st_reg.watchdog_program_reg[reset_ctrl_pkg::WATCHDOG_PROGRAM_REG_SOFT_BIT] && core_reset)
    else $error("bad sequence did not flag both");
  a_pin_holds: assert property (
    st_reg.pin_act |-> core_reset)
    else $error("pin active but core released");
  a_pof_warm: assert property (
    bod && !por && !req.wr |=>
    $stable(st_reg.power_control_reg[reset_ctrl_pkg::POWER_CONTROL_REG_POF_BIT]))
    else $error("warm reset changed power-off flag");

  c_hw_reset: cover property (ev_hw);
  c_sw_reset: cover property (run && seq_sw);
  c_kick: cover property (wdt_kick);
  c_pin_release: cover property ($fell(st_reg.pin_act));

endmodule

`default_nettype wire

/* sim/board_reset.sv */
// Purpose: Board-level reset circuitry on the shared reset pin
// Assumes: On-chip pull sits at the inactive level of the sense select
// Notes: Board drives through a series resistor, so the device wins
`timescale 1ns/1ps
`default_nettype none

module board_reset (
  input wire logic sense_select,
  input wire logic pin_out,
  input wire logic pin_oe_b,
  input wire logic hold_active,
  output logic pin_level
);
  always_comb begin
    if (!pin_oe_b) begin
      pin_level = pin_out;
    end else if (hold_active) begin
      pin_level = sense_select;
    end else begin
      pin_level = !sense_select;
    end
  end
endmodule

`default_nettype wire

/* sim/tb.sv */
// Purpose: Self-checking bench for reset_controller
// Assumes: Start-up table shortened to 8 cycles for every fuse setting
// Notes: Pulse lengths are counted at falling edges
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int STARTUP_DELAY_FUSES = 8;
  localparam int INIT = reset_ctrl_pkg::POR_INIT_CYC;
  localparam logic [7:0] PC = reset_ctrl_pkg::ADDR_POWER_CONTROL;
  localparam logic [7:0] WP = reset_ctrl_pkg::ADDR_WATCHDOG_PROGRAM;
  localparam logic [7:0] RS = reset_ctrl_pkg::ADDR_WATCHDOG_RESTART;
  logic clk, rst_b, por, bod, sel, fast, wdt, ca, wake, hold, pin, xtal;
  logic ifd;
  logic [1:0] fuses;
  reset_ctrl_pkg::reg_req_t req;
  logic [7:0] rdata, d, bad;
  logic core_reset, pin_out, oe_b, isp, clk_hold, kick;
  int errors, comparisons, len, r, p, q, h, n, kind, dis;
  bit drove;
  // Model: flags {overflow, soft}, pulse length, pin drive per event
  int fl [5] = '{1, 0, 2, 3, 3};
  int plen [5] = '{49, 16, 49, 49, 49};
  bit pdrv [5] = '{1, 0, 1, 1, 1};

  reset_controller #(
    .SUT_CYCLES({8{reset_ctrl_pkg::CNT_W'(STARTUP_DELAY_FUSES)}})
  ) uut (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
    .por_detect(por), .bod_low(bod), .rst_pin_in(pin),
    .reset_sense_select(sel), .startup_delay_fuses(fuses),
    .xtal_source(xtal), .fast_mode(fast), .isp_fuse_disable(ifd),
    .hw_wdt_timeout(wdt), .ca_wdt_match(ca), .pd_wake(wake),
    .core_reset(core_reset), .rst_pin_out(pin_out), .rst_pin_oe_b(oe_b),
    .isp_enable(isp), .core_clk_hold(clk_hold), .wdt_kick(kick));

  board_reset br (.sense_select(sel), .pin_out(pin_out),
    .pin_oe_b(oe_b), .hold_active(hold), .pin_level(pin));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----
  // Tasks
  // ----
  task automatic check_reg(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_len(string what, int lo, int hi, int got);
    comparisons++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
  endtask

  task automatic idle();
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 v = rdata;
  endtask

  task automatic pulse(int wmax, output int c, output bit dr);
    c = 0;
    dr = 0;
    for (int i = 0; i < wmax && core_reset !== 1'b1; i++) @(negedge clk);
    while (core_reset === 1'b1 && c < 20000) begin
      dr |= (oe_b === 1'b0);
      c++;
      @(negedge clk);
    end
  endtask

  task automatic watch(int c, output int rr, output int pp, output int qq,
                       output int hh);
    {rr, pp, qq, hh} = '0;
    repeat (c) begin
      @(negedge clk);
      rr += (core_reset === 1'b1);
      pp += (oe_b === 1'b0);
      qq += (kick === 1'b1);
      hh += (clk_hold === 1'b1);
    end
  endtask

  task automatic end_of_test();
    $display("counts errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("BAD watchdog expected done seen timeout");
    end_of_test();
  end

  // ----
  // Tests
  // ----
  initial begin
    n = $urandom(45070);
    {rst_b, bod, sel, wdt, ca, wake, hold, ifd} = '0;
    {por, fast} = 2'b11;
    req = '0;
    {fuses, xtal} = 3'($urandom);
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check_reg("por pin drive", 8'h00, 8'(oe_b));
    @(posedge clk);
    por <= 1'b0;
    pulse(1, len, drove);
    check_len("por release", INIT + STARTUP_DELAY_FUSES, INIT + STARTUP_DELAY_FUSES + 12, len);
    rd(PC, d);
    check_reg("power_control_reg", 8'h10, d);
    $display("test por done");
    wr(PC, 8'h0c);
    idle();
    rd(PC, d);
    check_reg("power_control_reg write", 8'h0c, d);
    @(posedge clk);
    bod <= 1'b1;
    watch(100, r, p, q, h);
    check_len("bod reset", 96, 100, r);
    check_len("bod pin drive", 0, 0, p);
    @(posedge clk);
    bod <= 1'b0;
    pulse(1, len, drove);
    check_len("bod release", STARTUP_DELAY_FUSES, STARTUP_DELAY_FUSES + 6, len);
    rd(PC, d);
    check_reg("power_control_reg after bod", 8'h00, d);
    $display("test brownout done");
    for (int i = 0; i < 10; i++) begin
      kind = i % 5;
      dis = i / 5;
      bad = 8'($urandom);
      if (bad == 8'h5a || bad == 8'h1e || bad == 8'ha5) bad = 8'h00;
      wr(WP, {2'b00, dis[0], 5'h00});
      idle();
      case (kind)
        0, 3: begin
          wr(RS, 8'h5a);
          wr(RS, kind == 0 ? 8'ha5 : bad);
        end
        4: wr(RS, bad);
        default: begin
          @(posedge clk);
          ca <= (kind == 1);
          wdt <= (kind == 2);
        end
      endcase
      @(posedge clk);
      {req, ca, wdt} <= '0;
      pulse(10, len, drove);
      check_len("pulse", plen[kind], plen[kind], len);
      check_reg("pulse pin", 8'(pdrv[kind] && dis == 0), 8'(drove));
      rd(WP, d);
      check_reg("wdt flags", 8'(fl[kind] << 6), d);
    end
    $display("test events done");
    wr(RS, 8'h1e);
    wr(RS, 8'he1);
    idle();
    watch(6, r, p, q, h);
    check_len("kick", 1, 1, q);
    check_len("kick reset", 0, 0, r);
    wr(PC, 8'h20);
    idle();
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    watch(STARTUP_DELAY_FUSES + 10, r, p, q, h);
    check_len("wake hold", STARTUP_DELAY_FUSES, STARTUP_DELAY_FUSES + 2, h);
    check_len("wake reset", 0, 0, r);
    $display("test kick and wake done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {fast, sel} <= 2'(i);
      ifd <= i[0];
      repeat (12) @(posedge clk);
      hold <= 1'b1;
      @(posedge clk);
      hold <= 1'b0;
      watch(10, r, p, q, h);
      check_len("glitch", 0, 0, r);
      n = 6 + $urandom_range(20);
      @(posedge clk);
      hold <= 1'b1;
      repeat (n) @(posedge clk);
      @(negedge clk);
      check_reg("pin reset", 8'h01, 8'(core_reset));
      check_reg("isp", 8'(!i[0]), 8'(isp));
      @(posedge clk);
      hold <= 1'b0;
      pulse(1, len, drove);
      check_len("pin release", i >= 2 ? 2 : 7, i >= 2 ? 6 : 18, len);
    end
    $display("test pin done");
    end_of_test();
  end
endmodule

`default_nettype wire
